// >>> hw/pwt_pkg.sv
// page walk translator: shared constants, register map and types
// assumes a 25 MHz core clock and a 32-bit Avalon-MM register bus
package pwt_pkg;

  typedef enum logic [1:0] {
    PWT_MODE_NONE = 2'b00,
    PWT_MODE_32   = 2'b01,
    PWT_MODE_WIDE = 2'b10,
    PWT_MODE_LONG = 2'b11
  } pwt_mode_t;

  typedef enum logic [1:0] {
    PWT_ST_IDLE = 2'b00,
    PWT_ST_READ = 2'b01,
    PWT_ST_EVAL = 2'b10
  } pwt_state_t;

  typedef enum logic [1:0] {
    PWT_PG_4K = 2'b00,
    PWT_PG_4M = 2'b01,
    PWT_PG_2M = 2'b10,
    PWT_PG_1G = 2'b11
  } pwt_pgsz_t;

  // sizes of the structures in memory
  localparam int TBL_BYTES  = 4096;
  localparam int ENT32_CNT  = 1024;
  localparam int ENT64_CNT  = 512;
  localparam int ROOT_WIDE  = 4;
  localparam int OFS_W      = $clog2(TBL_BYTES);
  localparam int IDX32_W    = $clog2(ENT32_CNT);
  localparam int IDX64_W    = $clog2(ENT64_CNT);
  localparam int IDXW_W     = $clog2(ROOT_WIDE);
  localparam int PA_W       = 52;
  localparam int LA_W       = 48;

  // capability report of this device
  localparam logic        HAS_EXT_LEAF = 1'b1;
  localparam logic        HAS_LEAF8    = 1'b1;
  localparam logic [31:0] CAP_L1_EDX   = 32'h0003_2048;
  localparam logic [31:0] CAP_L1_ECX   = 32'h0002_0000;
  localparam logic [31:0] CAP_L7_EBX   = 32'h0000_0080;
  localparam logic [31:0] CAP_X1_EDX   = 32'h2410_0000;
  localparam int CAP_LPE_BIT  = 3;
  localparam int CAP_WPE_BIT  = 6;
  localparam int CAP_GPG_BIT  = 13;
  localparam int CAP_ATTR_BIT = 16;
  localparam int CAP_P40_BIT  = 17;
  localparam int CAP_CTX_BIT  = 17;
  localparam int CAP_SEP_BIT  = 7;
  localparam int CAP_XD_BIT   = 20;
  localparam int CAP_GIGA_BIT = 26;
  localparam int CAP_LM_BIT   = 29;
  localparam logic [7:0] PHYS_W_RPT  = 8'h24;
  localparam logic [7:0] PHYS_W_MAX  = 8'h34;
  localparam logic [7:0] PHYS_W_WIDE = 8'h24;
  localparam logic [7:0] PHYS_W_BASE = 8'h20;
  localparam logic [7:0] LIN_W_LONG  = 8'h30;
  localparam logic [7:0] LIN_W_BASE  = 8'h20;
  localparam logic [7:0] PHYS_W = !HAS_LEAF8 ?
    (CAP_L1_EDX[CAP_WPE_BIT] ? PHYS_W_WIDE : PHYS_W_BASE) :
    (PHYS_W_RPT > PHYS_W_MAX ? PHYS_W_MAX : PHYS_W_RPT);
  localparam logic [7:0] LIN_W = (HAS_LEAF8 && HAS_EXT_LEAF &&
    CAP_X1_EDX[CAP_LM_BIT]) ? LIN_W_LONG : LIN_W_BASE;
  localparam logic GIGA_OK = HAS_EXT_LEAF & CAP_X1_EDX[CAP_GIGA_BIT];
  localparam logic ATTR_OK = CAP_L1_EDX[CAP_ATTR_BIT];
  localparam int   M40     = (PHYS_W > 8'h28) ? 40 : int'(PHYS_W);

  // control bit positions
  localparam int CTL_LPE = 4;
  localparam int CTL_WPE = 5;
  localparam int CTL_GPG = 7;
  localparam int CTL_CTX = 17;
  localparam int CTL_SEP = 20;
  localparam int EXT_PG  = 0;
  localparam int EXT_LME = 8;
  localparam int EXT_XDE = 11;
  localparam logic [31:0] FEAT_WMASK =
    (32'(CAP_L1_EDX[CAP_LPE_BIT]) << CTL_LPE) |
    (32'(CAP_L1_EDX[CAP_WPE_BIT]) << CTL_WPE) |
    (32'(CAP_L1_EDX[CAP_GPG_BIT]) << CTL_GPG) |
    (32'(CAP_L1_ECX[CAP_CTX_BIT]) << CTL_CTX) |
    (32'(CAP_L7_EBX[CAP_SEP_BIT]) << CTL_SEP);
  localparam logic [31:0] EXT_WMASK = (32'h1 << EXT_PG) |
    (32'(HAS_EXT_LEAF & CAP_X1_EDX[CAP_XD_BIT]) << EXT_XDE) |
    (32'(HAS_EXT_LEAF & CAP_X1_EDX[CAP_LM_BIT]) << EXT_LME);
  localparam logic [31:0] ALL_WMASK = 32'hffff_ffff;

  // entry fields and reserved-bit masks
  localparam int ENT_P      = 0;
  localparam int ENT_PWT    = 3;
  localparam int ENT_PCD    = 4;
  localparam int ENT_PS     = 7;
  localparam int ENT_PAT_LG = 12;
  localparam int ENT_XD     = 63;
  localparam logic [63:0] RSV_HI =
    (64'h1 << PA_W) - (64'h1 << PHYS_W);
  localparam logic [63:0] RSV_2M = 64'h0000_0000_001f_e000;
  localparam logic [63:0] RSV_1G = 64'h0000_0000_3fff_e000;
  localparam logic [63:0] RSV_4M = CAP_L1_EDX[CAP_P40_BIT] ?
    (64'h40_0000 - (64'h1 << (M40 - 19))) : 64'h0000_0000_003f_e000;

  // register byte offsets and reset values
  localparam logic [5:0] REG_CAP1D  = 6'h00;
  localparam logic [5:0] REG_CAP1C  = 6'h04;
  localparam logic [5:0] REG_CAP7B  = 6'h08;
  localparam logic [5:0] REG_CAPX1  = 6'h0c;
  localparam logic [5:0] REG_CAPX8  = 6'h10;
  localparam logic [5:0] REG_FEAT   = 6'h14;
  localparam logic [5:0] REG_EXT    = 6'h18;
  localparam logic [5:0] REG_ROOTL  = 6'h1c;
  localparam logic [5:0] REG_ROOTH  = 6'h20;
  localparam logic [5:0] REG_ATTR   = 6'h24;
  localparam logic [5:0] REG_STAT   = 6'h28;
  localparam logic [5:0] REG_PHYSL  = 6'h2c;
  localparam logic [5:0] REG_PHYSH  = 6'h30;
  localparam logic [5:0] REG_COUNT  = 6'h34;
  localparam logic [31:0] FEAT_RST  = 32'h0000_0000;
  localparam logic [31:0] EXT_RST   = 32'h0000_0000;
  localparam logic [31:0] ROOT_RST  = 32'h0000_0000;
  localparam logic [31:0] ATTR_RST  = 32'h7654_3210;

endpackage : pwt_pkg

// >>> hw/pwt_ent_if.sv
// carries one fetched entry to the entry checker and its verdict back
// assumes both ends run on the same core clock
`timescale 1ns/1ps
interface pwt_ent_if;
  pwt_pkg::pwt_mode_t mode;
  logic [1:0]         lvl;
  logic [63:0]        entry;
  logic               large_page_ext;
  logic               exec_disable_enable;
  logic               fault;
  logic               leaf;
  pwt_pkg::pwt_pgsz_t pgsz;
  logic [2:0]         attr_idx;
  modport chk  (input mode, lvl, entry, large_page_ext, exec_disable_enable,
                output fault, leaf, pgsz, attr_idx);
  modport walk (output mode, lvl, entry, large_page_ext, exec_disable_enable,
                input fault, leaf, pgsz, attr_idx);
endinterface : pwt_ent_if

// >>> hw/pwt_ctl_reg.sv
// one software register with byte enables and a mask of writable bits
// assumes writes arrive as single-cycle strobes
`timescale 1ns/1ps
module pwt_ctl_reg #(
  parameter logic [31:0] RST   = 32'h0,
  parameter logic [31:0] WMASK = 32'hffff_ffff
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  be_i,
  input  wire logic [31:0] wd_i,
  output logic      [31:0] q_o
);
  logic [31:0] bm;
  assign bm = {{8{be_i[3]}}, {8{be_i[2]}}, {8{be_i[1]}}, {8{be_i[0]}}}
              & WMASK;
  // bits outside the mask stay at reset: unsupported controls refuse 1
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q_o <= RST;
    end else if (we_i) begin
      q_o <= (q_o & ~bm) | (wd_i & bm);
    end
  end
endmodule : pwt_ctl_reg

// >>> hw/pwt_ent_chk.sv
// classifies one paging entry: fault, maps a page, or references a table
// assumes the entry of 32-bit mode arrives zero-extended to 64 bits
`timescale 1ns/1ps
module pwt_ent_chk (
  pwt_ent_if.chk ent
);
  logic [63:0] rsv;
  logic        ps_bad;
  logic        ps;
  always_comb begin
    rsv        = 64'h0;
    ps_bad     = 1'b0;
    ent.leaf   = 1'b0;
    ent.pgsz   = pwt_pkg::PWT_PG_4K;
    ps         = ent.entry[pwt_pkg::ENT_PS];
    case (ent.mode)
      pwt_pkg::PWT_MODE_32: begin
        if (ent.lvl == 2'd0) begin
          ent.leaf = 1'b1;
        end else if (ps && ent.large_page_ext) begin
          ent.leaf = 1'b1;
          ent.pgsz = pwt_pkg::PWT_PG_4M;
          rsv      = ent.entry & pwt_pkg::RSV_4M;
        end
      end
      pwt_pkg::PWT_MODE_WIDE, pwt_pkg::PWT_MODE_LONG: begin
        rsv = ent.entry & pwt_pkg::RSV_HI;
        rsv[pwt_pkg::ENT_XD] = ent.entry[pwt_pkg::ENT_XD] & ~ent.exec_disable_enable;
        if (ent.lvl == 2'd0) begin
          ent.leaf = 1'b1;
        end else if (ps) begin
          if (ent.lvl == 2'd1) begin
            ent.leaf = 1'b1;
            ent.pgsz = pwt_pkg::PWT_PG_2M;
            rsv      = rsv | (ent.entry & pwt_pkg::RSV_2M);
          end else if (ent.lvl == 2'd2 &&
                       ent.mode == pwt_pkg::PWT_MODE_LONG &&
                       pwt_pkg::GIGA_OK) begin
            ent.leaf = 1'b1;
            ent.pgsz = pwt_pkg::PWT_PG_1G;
            rsv      = rsv | (ent.entry & pwt_pkg::RSV_1G);
          end else begin
            ps_bad = 1'b1;
          end
        end
      end
      default: begin
        ent.leaf = 1'b1;
      end
    endcase
    ent.fault    = ~ent.entry[pwt_pkg::ENT_P] | (|rsv) | ps_bad;
    ent.attr_idx = {(ent.pgsz == pwt_pkg::PWT_PG_4K) ?
                    ent.entry[pwt_pkg::ENT_PS] :
                    ent.entry[pwt_pkg::ENT_PAT_LG],
                    ent.entry[pwt_pkg::ENT_PCD],
                    ent.entry[pwt_pkg::ENT_PWT]};
  end
endmodule : pwt_ent_chk

// >>> hw/pwt_walker.sv
// page walk translator: control registers, capability report and walker
// assumes a memory that answers each read with one valid pulse and a core
// that holds its request until it sees the ready flag high
`timescale 1ns/1ps

module pwt_walker (
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  // register bus
  input  wire logic [5:0]  AV_ADDRESS_I,
  input  wire logic        AV_READ_I,
  input  wire logic        AV_WRITE_I,
  input  wire logic [3:0]  AV_BYTEENABLE_I,
  input  wire logic [31:0] AV_WRITEDATA_I,
  output logic      [31:0] AV_READDATA_O,
  output logic             AV_WAITREQUEST_O,
  // translation request from the core
  input  wire logic        REQ_VALID_I,
  input  wire logic [47:0] REQ_LIN_I,
  output logic             REQ_READY_O,
  output logic             RSP_VALID_O,
  output logic             RSP_FAULT_O,
  output logic      [51:0] RSP_PHYS_O,
  output logic      [2:0]  RSP_MTYPE_O,
  // paging structure memory
  output logic             MEM_RD_O,
  output logic      [51:0] MEM_ADDR_O,
  input  wire logic [63:0] MEM_RDATA_I,
  input  wire logic        MEM_VALID_I
);

  logic [31:0]          feat_q;
  logic [31:0]          ext_q;
  logic [31:0]          attr_q;
  logic [31:0]          root_lo_q;
  logic [31:0]          root_hi_q;
  logic [51:0]          root;
  logic                 bus_wr;
  logic [31:0]          rd_d;
  pwt_pkg::pwt_mode_t   cur_mode;
  logic                 cfg_bad;
  pwt_pkg::pwt_state_t  state_q;
  pwt_pkg::pwt_mode_t   mode_q;
  logic [1:0]           lvl_q;
  logic [47:0]          lin_q;
  logic [51:0]          tbl_q;
  logic [63:0]          ent_q;
  pwt_pkg::pwt_pgsz_t   pgsz_q;
  logic [15:0]          xlat_cnt_q;
  logic [15:0]          fault_cnt_q;
  logic                 accept;
  logic [47:0]          req_lin;
  logic [1:0]           start_lvl;
  logic [51:0]          start_tbl;
  logic [51:0]          next_tbl;

  pwt_ent_if ent_bus ();

  assign root    = {root_hi_q[19:0], root_lo_q};
  assign bus_wr  = AV_WRITE_I & ~AV_WAITREQUEST_O;
  assign accept  = REQ_VALID_I & REQ_READY_O;

  // writable controls: masks keep unsupported features at zero
  pwt_ctl_reg #(
    .RST   (pwt_pkg::FEAT_RST),
    .WMASK (pwt_pkg::FEAT_WMASK)
  ) u_feat (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .we_i    (bus_wr && AV_ADDRESS_I == pwt_pkg::REG_FEAT),
    .be_i    (AV_BYTEENABLE_I),
    .wd_i    (AV_WRITEDATA_I),
    .q_o     (feat_q)
  );

  pwt_ctl_reg #(
    .RST   (pwt_pkg::EXT_RST),
    .WMASK (pwt_pkg::EXT_WMASK)
  ) u_ext (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .we_i    (bus_wr && AV_ADDRESS_I == pwt_pkg::REG_EXT),
    .be_i    (AV_BYTEENABLE_I),
    .wd_i    (AV_WRITEDATA_I),
    .q_o     (ext_q)
  );

  pwt_ctl_reg #(
    .RST   (pwt_pkg::ATTR_RST),
    .WMASK (pwt_pkg::ALL_WMASK)
  ) u_attr (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .we_i    (bus_wr && AV_ADDRESS_I == pwt_pkg::REG_ATTR),
    .be_i    (AV_BYTEENABLE_I),
    .wd_i    (AV_WRITEDATA_I),
    .q_o     (attr_q)
  );

  pwt_ctl_reg #(
    .RST   (pwt_pkg::ROOT_RST),
    .WMASK (pwt_pkg::ALL_WMASK)
  ) u_root_lo (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .we_i    (bus_wr && AV_ADDRESS_I == pwt_pkg::REG_ROOTL),
    .be_i    (AV_BYTEENABLE_I),
    .wd_i    (AV_WRITEDATA_I),
    .q_o     (root_lo_q)
  );

  pwt_ctl_reg #(
    .RST   (pwt_pkg::ROOT_RST),
    .WMASK (pwt_pkg::ALL_WMASK)
  ) u_root_hi (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .we_i    (bus_wr && AV_ADDRESS_I == pwt_pkg::REG_ROOTH),
    .be_i    (AV_BYTEENABLE_I),
    .wd_i    (AV_WRITEDATA_I),
    .q_o     (root_hi_q)
  );

  // one wait state on every access keeps read data a registered output
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      AV_WAITREQUEST_O <= 1'b1;
    end else begin
      AV_WAITREQUEST_O <= ~((AV_READ_I | AV_WRITE_I) & AV_WAITREQUEST_O);
    end
  end

  always_comb begin
    case (AV_ADDRESS_I)
      pwt_pkg::REG_CAP1D: rd_d = pwt_pkg::CAP_L1_EDX;
      pwt_pkg::REG_CAP1C: rd_d = pwt_pkg::CAP_L1_ECX;
      pwt_pkg::REG_CAP7B: rd_d = pwt_pkg::CAP_L7_EBX;
      pwt_pkg::REG_CAPX1: rd_d = pwt_pkg::HAS_EXT_LEAF ?
                                 pwt_pkg::CAP_X1_EDX : 32'h0;
      pwt_pkg::REG_CAPX8: rd_d = pwt_pkg::HAS_LEAF8 ?
        {16'h0, pwt_pkg::LIN_W, pwt_pkg::PHYS_W} : 32'h0;
      pwt_pkg::REG_FEAT:  rd_d = feat_q;
      pwt_pkg::REG_EXT:   rd_d = ext_q;
      pwt_pkg::REG_ROOTL: rd_d = root_lo_q;
      pwt_pkg::REG_ROOTH: rd_d = root_hi_q;
      pwt_pkg::REG_ATTR:  rd_d = attr_q;
      pwt_pkg::REG_STAT:  rd_d = {26'h0, 2'(pgsz_q), 2'(cur_mode),
                                  RSP_FAULT_O,
                                  state_q != pwt_pkg::PWT_ST_IDLE};
      pwt_pkg::REG_PHYSL: rd_d = RSP_PHYS_O[31:0];
      pwt_pkg::REG_PHYSH: rd_d = {12'h0, RSP_PHYS_O[51:32]};
      pwt_pkg::REG_COUNT: rd_d = {fault_cnt_q, xlat_cnt_q};
      default:            rd_d = 32'h0;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      AV_READDATA_O <= 32'h0;
    end else if (AV_READ_I && AV_WAITREQUEST_O) begin
      AV_READDATA_O <= rd_d;
    end
  end

  // mode select from the live controls
  always_comb begin
    cfg_bad = 1'b0;
    if (!ext_q[pwt_pkg::EXT_PG]) begin
      cur_mode = pwt_pkg::PWT_MODE_NONE;
    end else if (!feat_q[pwt_pkg::CTL_WPE]) begin
      cur_mode = pwt_pkg::PWT_MODE_32;
      cfg_bad  = ext_q[pwt_pkg::EXT_LME];
    end else if (ext_q[pwt_pkg::EXT_LME]) begin
      cur_mode = pwt_pkg::PWT_MODE_LONG;
    end else begin
      cur_mode = pwt_pkg::PWT_MODE_WIDE;
    end
  end

  // address of the entry selected at one level
  function automatic logic [51:0] f_ent_addr(
    input pwt_pkg::pwt_mode_t m,
    input logic [1:0]         l,
    input logic [51:0]        base,
    input logic [47:0]        lin
  );
    logic [8:0] idx9;
    idx9 = 9'h0;
    case (l)
      2'd3:    idx9 = lin[47:39];
      2'd2:    idx9 = lin[38:30];
      2'd1:    idx9 = lin[29:21];
      default: idx9 = lin[20:12];
    endcase
    if (m == pwt_pkg::PWT_MODE_32) begin
      f_ent_addr = {base[51:pwt_pkg::OFS_W],
                    (l != 2'd0) ? lin[31:22] : lin[21:12], 2'b00};
    end else if (m == pwt_pkg::PWT_MODE_WIDE && l == 2'd2) begin
      f_ent_addr = {base[51:5], lin[31:30], 3'b000};
    end else begin
      f_ent_addr = {base[51:pwt_pkg::OFS_W], idx9, 3'b000};
    end
  endfunction : f_ent_addr

  // final address from the mapping entry and the remaining offset
  function automatic logic [51:0] f_phys(
    input pwt_pkg::pwt_pgsz_t sz,
    input logic [63:0]        e,
    input logic [47:0]        lin
  );
    case (sz)
      pwt_pkg::PWT_PG_4M: f_phys = {12'h0, e[20:13], e[31:22],
                                    lin[21:0]};
      pwt_pkg::PWT_PG_2M: f_phys = {e[51:21], lin[20:0]};
      pwt_pkg::PWT_PG_1G: f_phys = {e[51:30], lin[29:0]};
      default:            f_phys = {e[51:12], lin[11:0]};
    endcase
  endfunction : f_phys

  // 32-bit and wide modes see only the low 32 linear bits
  assign req_lin   = (cur_mode == pwt_pkg::PWT_MODE_LONG) ?
                     REQ_LIN_I : {16'h0, REQ_LIN_I[31:0]};
  assign start_lvl = (cur_mode == pwt_pkg::PWT_MODE_LONG) ? 2'd3 :
                     (cur_mode == pwt_pkg::PWT_MODE_WIDE) ? 2'd2 : 2'd1;
  assign start_tbl = (cur_mode == pwt_pkg::PWT_MODE_LONG) ?
                     {root[51:12], 12'h0} :
                     (cur_mode == pwt_pkg::PWT_MODE_WIDE) ?
                     {20'h0, root[31:5], 5'h0} :
                     {20'h0, root[31:12], 12'h0};
  assign next_tbl  = {ent_q[51:12], 12'h0};

  assign ent_bus.mode  = mode_q;
  assign ent_bus.lvl   = lvl_q;
  assign ent_bus.entry = ent_q;
  assign ent_bus.large_page_ext   = feat_q[pwt_pkg::CTL_LPE];
  assign ent_bus.exec_disable_enable   = ext_q[pwt_pkg::EXT_XDE];

  pwt_ent_chk u_chk (
    .ent (ent_bus)
  );

  // walker: a level is read, held, then classified
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      state_q     <= pwt_pkg::PWT_ST_IDLE;
      mode_q      <= pwt_pkg::PWT_MODE_NONE;
      lvl_q       <= 2'd0;
      lin_q       <= 48'h0;
      tbl_q       <= 52'h0;
      ent_q       <= 64'h0;
      REQ_READY_O <= 1'b0;
      MEM_RD_O    <= 1'b0;
      MEM_ADDR_O  <= 52'h0;
    end else begin
      case (state_q)
        pwt_pkg::PWT_ST_IDLE: begin
          REQ_READY_O <= 1'b1;
          if (accept) begin
            REQ_READY_O <= 1'b0;
            mode_q      <= cur_mode;
            lin_q       <= req_lin;
            if (cur_mode != pwt_pkg::PWT_MODE_NONE && !cfg_bad) begin
              state_q    <= pwt_pkg::PWT_ST_READ;
              lvl_q      <= start_lvl;
              tbl_q      <= start_tbl;
              MEM_RD_O   <= 1'b1;
              MEM_ADDR_O <= f_ent_addr(cur_mode, start_lvl, start_tbl,
                                       req_lin);
            end
          end
        end
        pwt_pkg::PWT_ST_READ: begin
          if (MEM_VALID_I) begin
            MEM_RD_O <= 1'b0;
            state_q  <= pwt_pkg::PWT_ST_EVAL;
            ent_q    <= (mode_q == pwt_pkg::PWT_MODE_32) ?
                        {32'h0, MEM_RDATA_I[31:0]} : MEM_RDATA_I;
          end
        end
        pwt_pkg::PWT_ST_EVAL: begin
          if (ent_bus.fault || ent_bus.leaf) begin
            state_q     <= pwt_pkg::PWT_ST_IDLE;
            REQ_READY_O <= 1'b1;
          end else begin
            state_q    <= pwt_pkg::PWT_ST_READ;
            lvl_q      <= lvl_q - 2'd1;
            tbl_q      <= next_tbl;
            MEM_RD_O   <= 1'b1;
            MEM_ADDR_O <= f_ent_addr(mode_q, lvl_q - 2'd1, next_tbl,
                                     lin_q);
          end
        end
        default: begin
          state_q <= pwt_pkg::PWT_ST_IDLE;
        end
      endcase
    end
  end

  // reply to the core, one pulse per request
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      RSP_VALID_O <= 1'b0;
      RSP_FAULT_O <= 1'b0;
      RSP_PHYS_O  <= 52'h0;
      RSP_MTYPE_O <= 3'h0;
      pgsz_q      <= pwt_pkg::PWT_PG_4K;
    end else begin
      RSP_VALID_O <= 1'b0;
      if (state_q == pwt_pkg::PWT_ST_IDLE && accept &&
          (cur_mode == pwt_pkg::PWT_MODE_NONE || cfg_bad)) begin
        RSP_VALID_O <= 1'b1;
        RSP_FAULT_O <= cfg_bad;
        RSP_PHYS_O  <= cfg_bad ? 52'h0 : {20'h0, REQ_LIN_I[31:0]};
        RSP_MTYPE_O <= pwt_pkg::ATTR_OK ? attr_q[2:0] : 3'h0;
        pgsz_q      <= pwt_pkg::PWT_PG_4K;
      end else if (state_q == pwt_pkg::PWT_ST_EVAL &&
                   (ent_bus.fault || ent_bus.leaf)) begin
        RSP_VALID_O <= 1'b1;
        RSP_FAULT_O <= ent_bus.fault;
        RSP_PHYS_O  <= ent_bus.fault ? 52'h0 :
                       f_phys(ent_bus.pgsz, ent_q, lin_q);
        RSP_MTYPE_O <= pwt_pkg::ATTR_OK ?
                       attr_q[{ent_bus.attr_idx, 2'b00} +: 3] : 3'h0;
        pgsz_q      <= ent_bus.pgsz;
      end
    end
  end

  // counters saturate so software never sees them wrap to zero
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      xlat_cnt_q  <= 16'h0;
      fault_cnt_q <= 16'h0;
    end else if (RSP_VALID_O) begin
      if (RSP_FAULT_O && fault_cnt_q != 16'hffff) begin
        fault_cnt_q <= fault_cnt_q + 16'h1;
      end else if (!RSP_FAULT_O && xlat_cnt_q != 16'hffff) begin
        xlat_cnt_q <= xlat_cnt_q + 16'h1;
      end
    end
  end

endmodule : pwt_walker

// >>> verification/pwt_mem_model.sv
// partner memory holding paging entries, answering reads late
// assumes the walker holds rd and address until valid is seen
`timescale 1ns/1ps
module pwt_mem_model (
  // clock
  input  wire logic        clk_i,
  // read port
  input  wire logic        rd_i,
  input  wire logic [51:0] addr_i,
  output logic      [63:0] rdata_o,
  output logic             valid_o
);
  logic [63:0] m [logic [51:0]];
  int          cnt = 0;
  int          lat = 1;
  initial rdata_o = 64'h0;
  initial valid_o = 1'b0;
  // idle data toggles so a stale sample never passes for an entry
  always @(posedge clk_i) begin
    valid_o <= 1'b0;
    rdata_o <= ~rdata_o;
    cnt     <= (rd_i && !valid_o) ? cnt + 1 : 0;
    if (rd_i && !valid_o && cnt >= lat) begin
      valid_o <= 1'b1;
      rdata_o <= m.exists(addr_i) ? m[addr_i] : 64'h0;
      lat     <= 3 - lat;
    end
  end
endmodule : pwt_mem_model

// >>> verification/pwt_walker_chk.sv
// assertions on the walker's bus, request and memory handshakes
// assumes a bind onto pwt_walker, whose ports share these names
`timescale 1ns/1ps
module pwt_walker_chk (
  // clock and reset
  input wire logic        CLK_I,
  input wire logic        RST_N_I,
  // bus and core
  input wire logic        AV_READ_I,
  input wire logic        AV_WRITE_I,
  input wire logic        AV_WAITREQUEST_O,
  input wire logic        REQ_VALID_I,
  input wire logic        REQ_READY_O,
  input wire logic        RSP_VALID_O,
  input wire logic        RSP_FAULT_O,
  input wire logic [51:0] RSP_PHYS_O,
  // memory
  input wire logic        MEM_RD_O,
  input wire logic [51:0] MEM_ADDR_O,
  input wire logic        MEM_VALID_I
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  chk_bus_answer:
    assert property ($rose(AV_READ_I | AV_WRITE_I) |=> !AV_WAITREQUEST_O)
    else $error("bus answer late");
  chk_bus_pulse:
    assert property (!AV_WAITREQUEST_O |=> AV_WAITREQUEST_O)
    else $error("bus answer too long");
  chk_take_drop:
    assert property (REQ_VALID_I && REQ_READY_O |=> !REQ_READY_O)
    else $error("ready kept after take");
  chk_reply_pulse:
    assert property (RSP_VALID_O |-> (REQ_READY_O ||
      $past(REQ_VALID_I && REQ_READY_O)) ##1 !RSP_VALID_O)
    else $error("reply pulse wrong");
  chk_mem_hold:
    assert property (MEM_RD_O && !MEM_VALID_I |=>
      MEM_RD_O && $stable(MEM_ADDR_O)) else $error("read not held");
  chk_mem_drop:
    assert property (MEM_RD_O && MEM_VALID_I |=> !MEM_RD_O)
    else $error("read kept after answer");
  chk_idle_quiet:
    assert property (REQ_READY_O |-> !MEM_RD_O) else $error("idle read");
  chk_fault_zero:
    assert property (RSP_VALID_O && RSP_FAULT_O |-> RSP_PHYS_O == 52'h0)
    else $error("fault with address");
  cover property (RSP_VALID_O && RSP_FAULT_O);
  cover property (RSP_VALID_O && !RSP_FAULT_O);
  cover property (MEM_RD_O && MEM_VALID_I);
endmodule : pwt_walker_chk

// >>> verification/pwt_walker_bench.sv
// bench: registers, paging off, 32-bit, long-mode (ends at a 2M page) and wide-mode walks
// assumes the walker, memory model and checker are compiled first
`timescale 1ns/1ps
module pwt_walker_bench;
  logic        CLK_I = 1'b0;
  logic        RST_N_I = 1'b0;
  logic [5:0]  AV_ADDRESS_I = 6'h0;
  logic        AV_READ_I = 1'b0;
  logic        AV_WRITE_I = 1'b0;
  logic [3:0]  AV_BYTEENABLE_I = 4'hf;
  logic [31:0] AV_WRITEDATA_I = 32'h0;
  logic [31:0] AV_READDATA_O;
  logic        AV_WAITREQUEST_O, REQ_READY_O, RSP_VALID_O, RSP_FAULT_O;
  logic        REQ_VALID_I = 1'b0;
  logic [47:0] REQ_LIN_I = 48'h0;
  logic [51:0] RSP_PHYS_O, MEM_ADDR_O;
  logic [2:0]  RSP_MTYPE_O;
  logic        MEM_RD_O, MEM_VALID_I;
  logic [63:0] MEM_RDATA_I;
  logic [63:0] dq [$];
  logic [63:0] rq [$];
  int          errors = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          seed = 4;
  pwt_walker uut (.*);
  pwt_mem_model mem (.clk_i(CLK_I), .rd_i(MEM_RD_O), .addr_i(MEM_ADDR_O),
                     .rdata_o(MEM_RDATA_I), .valid_o(MEM_VALID_I));
  always #20 CLK_I = ~CLK_I;
  task automatic check(input logic [63:0] g, input logic [63:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask : check
  task automatic check_rsp(input logic [55:0] g, input logic [55:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t: reply %h expected %h", $time, g, e);
    end
  endtask : check_rsp
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge CLK_I);
    AV_ADDRESS_I   <= a;
    AV_WRITEDATA_I <= d;
    AV_WRITE_I     <= w;
    AV_READ_I      <= !w;
    do @(posedge CLK_I); while (AV_WAITREQUEST_O !== 1'b0);
    AV_WRITE_I <= 1'b0;
    AV_READ_I  <= 1'b0;
  endtask : bus
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    dq.push_back(64'(e));
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic xlat(input logic [47:0] la, input logic [63:0] e);
    @(posedge CLK_I);
    rq.push_back(e);
    REQ_LIN_I   <= la;
    REQ_VALID_I <= 1'b1;
    do @(posedge CLK_I); while (REQ_READY_O !== 1'b1);
    REQ_VALID_I <= 1'b0;
    do @(posedge CLK_I); while (REQ_READY_O !== 1'b1);
  endtask : xlat
  always @(posedge CLK_I) begin
    if (AV_READ_I && AV_WAITREQUEST_O === 1'b0)
      check(64'(AV_READDATA_O), dq.pop_front());
    if (RSP_VALID_O === 1'b1)
      check_rsp({RSP_MTYPE_O, RSP_FAULT_O, RSP_PHYS_O},
                56'(rq.pop_front()));
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      check(64'h0, 64'h1);
      tally_and_finish();
    end
  end
  initial begin
    logic [5:0]  ra [6] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h3c};
    logic [31:0] re [6] = '{pwt_pkg::CAP_L1_EDX, pwt_pkg::CAP_L1_ECX,
      pwt_pkg::CAP_L7_EBX, pwt_pkg::CAP_X1_EDX, 32'h0000_3024, 32'h0};
    logic [47:0] la;
    mem.m[52'h1000] = 64'h3001;
    mem.m[52'h1004] = 64'h2001;
    mem.m[52'h2008] = 64'h5_5019;
    mem.m[52'h100c] = 64'h140_1081;
    mem.m[52'h1008] = 64'h3001;
    mem.m[52'h3000] = 64'h4001;
    mem.m[52'h4008] = 64'h60_0081;
    repeat (8) @(posedge CLK_I);
    RST_N_I <= 1'b1;
    for (int i = 0; i < 6; i++)
      rd(ra[i], re[i]);
    bus(1'b1, 6'h14, 32'hffff_ffff);
    rd(6'h14, 32'h0012_00b0);
    bus(1'b1, 6'h18, 32'hffff_ffff);
    rd(6'h18, 32'h0000_0901);
    bus(1'b1, 6'h18, 32'h0);
    repeat (3) begin
      la = 48'({$random(seed), $random(seed)});
      xlat(la, 64'(la[31:0]));
    end
    bus(1'b1, 6'h1c, 32'h1000);
    bus(1'b1, 6'h14, 32'h0);
    bus(1'b1, 6'h18, 32'h1);
    xlat(48'h40_2abc, 64'h60_0000_0005_5abc);
    xlat(48'hc0_0123, 64'h10_0000_0000_0000);
    bus(1'b1, 6'h14, 32'h10);
    xlat(48'hc0_0123, 64'h80_0000_0140_0123);
    bus(1'b1, 6'h18, 32'h101);
    xlat(48'h1234, 64'h10_0000_0000_0000);
    bus(1'b1, 6'h14, 32'h20);
    xlat(48'h80_0020_1234, 64'h60_1234);
    bus(1'b1, 6'h18, 32'h1);
    xlat(48'h1567, 64'h80_0000_0060_0567);
    rd(6'h34, 32'h0002_0007);
    repeat (4) @(posedge CLK_I);
    tally_and_finish();
  end
endmodule : pwt_walker_bench
bind pwt_walker pwt_walker_chk chk (.*);
